// ==== common/status_sets_pkg.sv ====
// Purpose: Constants and types shared by the status register sets.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   All offsets are byte addresses.
package status_sets_pkg;

    // =====================================================================
    // Register map
    localparam logic [7:0] ADDR_QUES_RISE  = 8'h00; // Questionable rising-edge mask
    localparam logic [7:0] ADDR_USER_MASK  = 8'h04; // User enable mask
    localparam logic [7:0] ADDR_USER_EVENT = 8'h08; // User event, clear on read
    localparam logic [7:0] ADDR_USER_PULSE = 8'h0c; // User condition pulse, write only
    localparam logic [7:0] ADDR_USER_RISE  = 8'h10; // User rising-edge mask
    localparam logic [7:0] ADDR_USER_COND  = 8'h14; // User condition, read only
    localparam logic [7:0] ADDR_PRESET     = 8'h18; // Write any value: preset
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h1c; // Interrupt status, clear on read
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20; // Interrupt mask

    // =====================================================================
    // Field layout
    localparam int          MASK_W       = 15;         // Values 0 to 32767
    localparam logic [14:0] MASK_RESET   = 15'h0000;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
    localparam int          IRQ_W        = 2;
    localparam int          IRQ_EVENT    = 0;          // Event latched
    localparam int          IRQ_SUMMARY  = 1;          // User summary went high
    localparam logic [1:0]  IRQ_RESET    = 2'h0;

    typedef logic [MASK_W-1:0] mask_t;

    // APB request carrier
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } apb_req_t;

endpackage : status_sets_pkg

// ==== hdl/status_register_sets.sv ====
// Purpose: Questionable rising-edge mask and user-defined status set over APB.
// Assumes: Single clock; pulses and condition inputs synchronous to clk.
// Notes:   Zero wait states; unmapped addresses read zero with no error.
//
// Function
// RL1: A 15-bit rising-edge mask for the questionable set is loaded from a written value.
// RL2: Software writes the sum of bit weights to set several mask bits at once.
// RL3: Preset leaves the rising-edge and enable masks unchanged; only reset or writes do.
// RL4: A 15-bit user enable mask is loaded by a write and reads back as written.
// RL5: Reading the user event register returns the sum of weights of its set bits.
// RL6: The user event register clears right after it is read.
// RL7: Each user condition bit rests at zero and goes high for one cycle on a pulse write.
// RL8: A zero-to-one condition change with its rise mask bit set latches the event bit.
`timescale 1ns/1ps

module status_register_sets (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Questionable condition input
    input  wire logic [14:0] ques_cond,
    // Status outputs
    output logic [14:0]      ques_rise_event,
    output logic             user_summary,
    output logic             irq
);

    // =====================================================================
    // Bus decode
    status_sets_pkg::apb_req_t req;
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    wire access   = req.sel & ~req.enable;  // Setup phase; answer lands at access edge
    wire wr       = access & req.write;
    wire rd       = access & ~req.write;
    wire hit_qr   = (req.addr == status_sets_pkg::ADDR_QUES_RISE);
    wire hit_um   = (req.addr == status_sets_pkg::ADDR_USER_MASK);
    wire hit_ue   = (req.addr == status_sets_pkg::ADDR_USER_EVENT);
    wire hit_up   = (req.addr == status_sets_pkg::ADDR_USER_PULSE);
    wire hit_ur   = (req.addr == status_sets_pkg::ADDR_USER_RISE);
    wire hit_uc   = (req.addr == status_sets_pkg::ADDR_USER_COND);
    wire hit_pr   = (req.addr == status_sets_pkg::ADDR_PRESET);
    wire hit_is   = (req.addr == status_sets_pkg::ADDR_IRQ_STAT);
    wire hit_im   = (req.addr == status_sets_pkg::ADDR_IRQ_MASK);

    // Write data fields; bits above a field are ignored on write
    wire [14:0] wdata_mask = req.wdata[status_sets_pkg::MASK_W-1:0];
    wire [1:0]  wdata_irq  = req.wdata[status_sets_pkg::IRQ_W-1:0];

    // Widen a mask into a bus word
    function automatic logic [31:0] word15(input logic [14:0] v);
        word15 = {17'h00000, v};
    endfunction

    // =====================================================================
    // State
    logic [14:0] ques_rise_q, user_mask_q, user_rise_q, user_event_q, user_cond_q;
    logic [14:0] ques_prev_q, ques_event_q, user_prev_q;
    logic [1:0]  irq_stat_q, irq_mask_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, summary_q, irq_q;

    // =====================================================================
    // Next-state logic
    // RL1 RL2 load from written sum
    wire [14:0] ques_rise_d = (wr & hit_qr) ? wdata_mask : ques_rise_q;
    // RL4 enable mask load
    wire [14:0] user_mask_d = (wr & hit_um) ? wdata_mask : user_mask_q;
    wire [14:0] user_rise_d = (wr & hit_ur) ? wdata_mask : user_rise_q;
    // RL7 one-cycle condition pulse
    wire [14:0] user_cond_d = (wr & hit_up) ? wdata_mask : status_sets_pkg::MASK_RESET;
    // RL8 rising-edge detect
    wire [14:0] user_rise_hit = user_cond_q & ~user_prev_q & user_rise_q;
    wire [14:0] ques_rise_hit = ques_cond & ~ques_prev_q & ques_rise_q;
    // RL6 clear on read, preset clears; a new edge wins over the clear
    wire        ue_clear      = (rd & hit_ue) | (wr & hit_pr);
    wire [14:0] user_event_d  = (ue_clear ? status_sets_pkg::MASK_RESET : user_event_q)
                                | user_rise_hit;
    wire [14:0] ques_event_d  = ((wr & hit_pr) ? status_sets_pkg::MASK_RESET : ques_event_q)
                                | ques_rise_hit;
    wire        summary_d     = |(user_event_d & user_mask_q);
    // Interrupt events: set wins over read clear
    wire [1:0]  irq_set       = {summary_d & ~summary_q, |user_rise_hit};
    wire [1:0]  irq_stat_d    = ((rd & hit_is) ? status_sets_pkg::IRQ_RESET : irq_stat_q)
                                | irq_set;
    wire [1:0]  irq_mask_d    = (wr & hit_im) ? wdata_irq : irq_mask_q;

    // RL5 read sum of weights
    wire [31:0] rdata_d =
        hit_qr ? word15(ques_rise_q)  :
        hit_um ? word15(user_mask_q)  :
        hit_ue ? word15(user_event_q) :
        hit_ur ? word15(user_rise_q)  :
        hit_uc ? word15(user_cond_q)  :
        hit_is ? {30'h00000000, irq_stat_q} :
        hit_im ? {30'h00000000, irq_mask_q} :
                 status_sets_pkg::WORD_ZERO;

    // =====================================================================
    // Registers
    // RL3 preset does not touch masks
    // Questionable rise mask; only reset or a write may change it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ques_rise_q <= status_sets_pkg::MASK_RESET;
        end else begin
            ques_rise_q <= ques_rise_d;
        end
    end

    // RL4 user enable mask
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            user_mask_q <= status_sets_pkg::MASK_RESET;
        end else begin
            user_mask_q <= user_mask_d;
        end
    end

    // User rise mask, kept through preset like the others
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            user_rise_q <= status_sets_pkg::MASK_RESET;
        end else begin
            user_rise_q <= user_rise_d;
        end
    end

    // Interrupt mask, same layout as interrupt status
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_q <= status_sets_pkg::IRQ_RESET;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // RL7 condition pulse and edge history
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            user_cond_q <= status_sets_pkg::MASK_RESET;
            user_prev_q <= status_sets_pkg::MASK_RESET;
        end else begin
            user_cond_q <= user_cond_d;
            user_prev_q <= user_cond_q;
        end
    end

    // Questionable history; resets low, but ques_rise_q also resets low,
    // so a level held high through reset is not a rise on the first clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ques_prev_q <= status_sets_pkg::MASK_RESET;
        end else begin
            ques_prev_q <= ques_cond;
        end
    end

    // RL6 RL8 user event latch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            user_event_q <= status_sets_pkg::MASK_RESET;
        end else begin
            user_event_q <= user_event_d;
        end
    end

    // Questionable event latch, cleared only by preset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ques_event_q <= status_sets_pkg::MASK_RESET;
        end else begin
            ques_event_q <= ques_event_d;
        end
    end

    // Interrupt status, sticky until read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_q <= status_sets_pkg::IRQ_RESET;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // Summary and interrupt level, both registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            summary_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            summary_q <= summary_d;
            irq_q     <= |(irq_stat_d & irq_mask_d);
        end
    end

    // Bus answer: zero wait states, data registered at setup
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q  <= status_sets_pkg::WORD_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= rd ? rdata_d : status_sets_pkg::WORD_ZERO;
            pready_q  <= access;
            pslverr_q <= 1'b0;   // No access is refused
        end
    end

    // =====================================================================
    // Outputs
    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q; // Never errors; unmapped reads zero
    assign ques_rise_event = ques_event_q;
    assign user_summary    = summary_q;
    assign irq             = irq_q;

endmodule // status_register_sets

// ==== testbench/status_sets_props.sv ====
// Purpose: Port assertions for the status register sets.
// Assumes: Zero-wait APB slave on one clock.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module status_sets_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Bus handshake
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // Status
    input wire logic        user_summary,
    input wire logic [14:0] ques_cond,
    input wire logic [14:0] ques_rise_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup; psel && !penable; endsequence
    property p_rdy; s_setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("ready held");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data outside access");
    property p_wide; pready |-> prdata[31:15] == 17'h0; endproperty
    a_wide: assert property (p_wide) else $error("data above bit 14");
    property p_qev; (ques_rise_event & ~$past(ques_rise_event | ques_cond)) == 15'h0; endproperty
    a_qev: assert property (p_qev) else $error("event with no rise");
    property p_srise; $rose(user_summary) |->
        $past(psel && pwrite, 2) || $past(psel && pwrite, 3); endproperty
    a_srise: assert property (p_srise) else $error("summary rose unprompted");
    // Read clear or preset drops it one edge on; a mask write two edges on
    property p_sfall; $fell(user_summary) |->
        $past(psel && !penable) || $past(psel && !penable, 2); endproperty
    a_sfall: assert property (p_sfall) else $error("summary fell unprompted");
endmodule // status_sets_props

// ==== testbench/tb_status_register_sets.sv ====
// Purpose: Self-checking bench for the status register sets.
// Assumes: Master moves right after rising edges; one clock.
// Notes:   Integer mask copies give every expected value.
`timescale 1ns/1ps
module tb_status_register_sets;
    status_sets_pkg::apb_req_t q;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, user_summary, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [14:0] ques_cond, ques_rise_event;
    int          fail_count, checks, v, p, m[3];
    logic [7:0]  ma[3] = '{8'h00, 8'h04, 8'h10};
    // Request fields travel as one struct
    assign {psel, penable, pwrite, paddr, pwdata} = q;
    status_register_sets dut_u (
        .clk             (clk),
        .reset_n         (reset_n),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .ques_cond       (ques_cond),
        .ques_rise_event (ques_rise_event),
        .user_summary    (user_summary),
        .irq             (irq)
    );
    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // APB master: request held until pready is sampled high at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) q <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk) q.enable <= 1'b1;
        do begin
            @(posedge clk) n++;
        end while (pready !== 1'b1 && n < 9);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: ready %h vs %h", $time, pready, 1'b1);
            give_verdict();
        end else begin
            // Answer taken at the edge where ready is seen
            if (!w) chk(prdata, d);
            chk({31'h0, pslverr}, 32'h0);
            q <= '0;
        end
    endtask
    // Main sequence
    initial begin
        {q, reset_n, ques_cond} = '0;
        v = $urandom(32'h1320f9f7);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        // Random sums of weights, full scale in the middle pass; unmapped place reads zero
        for (int k = 0; k < 3; k++) begin
            foreach (m[j]) m[j] = (k == 1) ? 'h7fff : $urandom & 'h7fff | 1;
            foreach (m[j]) bus(1'b1, ma[j], m[j]);
            foreach (m[j]) bus(1'b0, ma[j], m[j]);
        end
        bus(1'b0, 8'h3c, 0);
        $display("test masks done");
        // Pulse raises irq and ques edges latch events; reads clear it; then masked, then preset
        p = $urandom & 'h7fff | 1;
        v = $urandom & 'h7fff;
        bus(1'b1, 8'h20, 3);
        bus(1'b1, 8'h0c, p);
        ques_cond <= v[14:0];
        repeat (5) @(posedge clk);
        chk({user_summary, irq, ques_rise_event}, {2'h3, v[14:0] & m[0][14:0]});
        bus(1'b0, 8'h14, 0);
        bus(1'b0, 8'h08, p & m[2]);
        bus(1'b0, 8'h08, 0);
        bus(1'b0, 8'h1c, 3);
        bus(1'b1, 8'h20, 0);
        bus(1'b1, 8'h0c, p);
        bus(1'b1, 8'h18, 0);
        foreach (m[j]) bus(1'b0, ma[j], m[j]);
        chk({user_summary, irq, ques_rise_event}, 0);
        $display("test events done");
        give_verdict();
    end
endmodule // tb_status_register_sets
bind status_register_sets status_sets_props u_props (
    .clk             (clk),
    .reset_n         (reset_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .pready          (pready),
    .prdata          (prdata),
    .user_summary    (user_summary),
    .ques_cond       (ques_cond),
    .ques_rise_event (ques_rise_event)
);
